// [hw/sensor_status_indicator_logic.sv]
// Target indicator, output status indicators and switch/analog control
`timescale 1ns/1ns
`default_nettype none
module sensor_status_indicator_logic #(
  parameter int unsigned NO_TARGET_TIMEOUT = status_pkg::NO_TARGET_CYCLES,
  parameter int unsigned FAST_HALF         = status_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_RATIO        = status_pkg::SLOW_RATIO,
  parameter int unsigned ACT_HOLD          = status_pkg::ACT_HOLD_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire status_pkg::targetIn_t    target,
  input  wire logic                     adjustButtonPin,
  input  wire status_pkg::switchIn_t    switch1,
  input  wire status_pkg::switchIn_t    switch2,
  input  wire logic                     atLowEnd,
  input  wire logic                     atHighEnd,
  input  wire logic                     rxActivity,
  input  wire logic                     txActivity,
  input  wire status_pkg::statusSel_t   squareSel,
  input  wire status_pkg::statusSel_t   rectSel,
  input  wire logic                     noTargetSwitchOff,
  input  wire logic                     noTargetAnalogHold,
  output status_pkg::ledOut_t           targetLed,
  output logic                          squareLed,
  output logic                          rectLed,
  output logic [1:0]                    switchDrive,
  output status_pkg::analogLevel_t      analogLevel,
  output logic                          filtersEnable,
  output logic                          measureEnable,
  output logic                          adjustHeld
);

  // ---------------------------------------------------------------
  // Pattern sources
  // ---------------------------------------------------------------
  logic fastBlink;
  logic slowBlink;
  logic dualBlink;
  logic rxFlash;
  logic txFlash;

  blink_gen #(
    .FAST_HALF  (FAST_HALF),
    .SLOW_RATIO (SLOW_RATIO)
  ) u_blink (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fast    (fastBlink),
    .slow    (slowBlink),
    .dual    (dualBlink)
  );

  pulse_stretch #(
    .HOLD (ACT_HOLD)
  ) u_rxFlash (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .trigger (rxActivity),
    .active  (rxFlash)
  );

  pulse_stretch #(
    .HOLD (ACT_HOLD)
  ) u_txFlash (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .trigger (txActivity),
    .active  (txFlash)
  );

  // ---------------------------------------------------------------
  // Adjust button synchroniser
  // ---------------------------------------------------------------
  logic buttonMeta;
  logic buttonSync;
  logic next_buttonMeta;
  logic next_buttonSync;

  always_comb
  begin
    next_buttonMeta = adjustButtonPin;
    next_buttonSync = buttonMeta;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buttonMeta <= 1'b0;
      buttonSync <= 1'b0;
    end
    else
    begin
      buttonMeta <= next_buttonMeta;
      buttonSync <= next_buttonSync;
    end
  end

  assign adjustHeld = buttonSync;

  // ---------------------------------------------------------------
  // Sync loss supervision
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_NOSYNC,
    ST_OVERRIDE
  } syncState_t;

  syncState_t syncState;
  syncState_t next_syncState;

  // The button ends the warning until sync is back or slave mode is left
  always_comb
  begin
    next_syncState = syncState;
    case (syncState)
      ST_RUN:
        if (target.syncSlave && target.syncLost)
          next_syncState = ST_NOSYNC;
      ST_NOSYNC:
        if (!target.syncSlave || !target.syncLost)
          next_syncState = ST_RUN;
        else if (buttonSync)
          next_syncState = ST_OVERRIDE;
      ST_OVERRIDE:
        if (!target.syncSlave || !target.syncLost)
          next_syncState = ST_RUN;
      default:
        next_syncState = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      syncState <= ST_RUN;
    else
      syncState <= next_syncState;
  end

  // ---------------------------------------------------------------
  // No-target timeout
  // ---------------------------------------------------------------
  localparam int TW = $clog2(NO_TARGET_TIMEOUT + 1);

  logic [TW-1:0] noTargetCnt;
  logic [TW-1:0] next_noTargetCnt;
  logic          noTargetExpired;
  logic          next_noTargetExpired;

  always_comb
  begin
    next_noTargetCnt = noTargetCnt;
    next_noTargetExpired = noTargetExpired;
    if (target.targetDetected)
    begin
      next_noTargetCnt = '0;
      next_noTargetExpired = 1'b0;
    end
    else if (noTargetCnt == TW'(NO_TARGET_TIMEOUT - 1))
      next_noTargetExpired = 1'b1;
    else
      next_noTargetCnt = noTargetCnt + TW'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      noTargetCnt <= '0;
      noTargetExpired <= 1'b0;
    end
    else
    begin
      noTargetCnt <= next_noTargetCnt;
      noTargetExpired <= next_noTargetExpired;
    end
  end

  // ---------------------------------------------------------------
  // Switch and analog control
  // ---------------------------------------------------------------
  logic [1:0]               next_switchDrive;
  status_pkg::analogLevel_t next_analogLevel;
  logic                     next_filtersEnable;
  logic                     next_measureEnable;
  logic                     switchesBlocked;

  always_comb
  begin
    switchesBlocked = noTargetSwitchOff && noTargetExpired;
    // Drive means conducting, whatever the output polarity
    next_switchDrive[0] = switch1.request && !switch1.fault
                          && !switchesBlocked;
    next_switchDrive[1] = switch2.request && !switch2.fault
                          && !switchesBlocked;
    if (!target.targetDetected && noTargetAnalogHold)
      next_analogLevel = status_pkg::ANA_HOLD;
    else if (atHighEnd)
      next_analogLevel = status_pkg::ANA_HIGH;
    else if (atLowEnd)
      next_analogLevel = status_pkg::ANA_LOW;
    else
      next_analogLevel = status_pkg::ANA_TRACK;
    next_filtersEnable = !target.unlocked;
    next_measureEnable = (syncState != ST_NOSYNC);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switchDrive <= 2'h0;
      analogLevel <= status_pkg::ANA_LOW;
      filtersEnable <= 1'b1;
      measureEnable <= 1'b1;
    end
    else
    begin
      switchDrive <= next_switchDrive;
      analogLevel <= next_analogLevel;
      filtersEnable <= next_filtersEnable;
      measureEnable <= next_measureEnable;
    end
  end

  // ---------------------------------------------------------------
  // Target indicator
  // ---------------------------------------------------------------
  status_pkg::ledOut_t next_targetLed;
  logic                feedbackAllowed;
  logic                lockBlink;

  always_comb
  begin
    feedbackAllowed = !(target.adjustDisabled && !target.syncMaster
                        && !target.syncSlave);
    lockBlink = target.alternateAdjustMode ? dualBlink
                                           : slowBlink;
    next_targetLed = '0;
    if (syncState == ST_NOSYNC)
    begin
      next_targetLed.red = slowBlink;
      next_targetLed.green = !slowBlink;
    end
    else if (buttonSync && feedbackAllowed)
      next_targetLed.red = lockBlink;
    else if (target.targetDetected)
    begin
      if (target.unlocked)
        next_targetLed.green = lockBlink;
      else if (target.nearMin)
        next_targetLed.green = fastBlink;
      else
        next_targetLed.green = 1'b1;
    end
    else
    begin
      if (target.unlocked)
        next_targetLed.red = lockBlink;
      else
        next_targetLed.red = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      targetLed <= '{red: 1'b1, green: 1'b0};
    else
      targetLed <= next_targetLed;
  end

  // ---------------------------------------------------------------
  // Output status indicators
  // ---------------------------------------------------------------
  logic next_squareLed;
  logic next_rectLed;
  logic analogShow;

  function automatic logic switchShow(
    input status_pkg::switchIn_t sw,
    input logic                  driven,
    input logic                  blink
  );
    if (sw.fault)
      return blink;
    return driven;
  endfunction

  function automatic logic statusShow(
    input status_pkg::statusSel_t sel,
    input logic                   analogV,
    input logic                   switchV,
    input logic                   rxV,
    input logic                   txV
  );
    case (sel)
      status_pkg::SEL_ANALOG:
        return analogV;
      status_pkg::SEL_SWITCH:
        return switchV;
      status_pkg::SEL_RX:
        return rxV;
      status_pkg::SEL_TX:
        return txV;
      default:
        return 1'b0;
    endcase
  endfunction

  always_comb
  begin
    if (atHighEnd)
      analogShow = fastBlink;
    else if (atLowEnd)
      analogShow = 1'b0;
    else
      analogShow = 1'b1;
    next_squareLed = statusShow(squareSel, analogShow,
                                switchShow(switch1, switchDrive[0],
                                           slowBlink),
                                rxFlash, txFlash);
    next_rectLed = statusShow(rectSel, analogShow,
                              switchShow(switch2, switchDrive[1],
                                         slowBlink),
                              rxFlash, txFlash);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      squareLed <= 1'b0;
      rectLed <= 1'b0;
    end
    else
    begin
      squareLed <= next_squareLed;
      rectLed <= next_rectLed;
    end
  end

endmodule
`default_nettype wire

// [hw/status_pkg.sv]
// Shared constants and types for the sensor status indicator logic
package status_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;

  // No-target switch timeout
  localparam int unsigned NO_TARGET_MS = 1000;
  localparam int unsigned NO_TARGET_CYCLES = CLK_KHZ * NO_TARGET_MS;

  // Half period of the fast flash
  localparam int unsigned FAST_HALF_MS = 50;
  localparam int unsigned FAST_HALF_CYCLES = CLK_KHZ * FAST_HALF_MS;

  // Slow blink half period as a multiple of fast half periods
  localparam int unsigned SLOW_RATIO = 5;

  // Least visible on-time of a serial activity flash
  localparam int unsigned ACT_HOLD_MS = 40;
  localparam int unsigned ACT_HOLD_CYCLES = CLK_KHZ * ACT_HOLD_MS;

  // Double blink pattern, one bit per fast half period
  localparam logic [7:0] DUAL_PATTERN = 8'h05;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_OFF,
    SEL_ANALOG,
    SEL_SWITCH,
    SEL_RX,
    SEL_TX
  } statusSel_t;

  typedef enum logic [1:0] {
    ANA_TRACK,
    ANA_LOW,
    ANA_HIGH,
    ANA_HOLD
  } analogLevel_t;

  typedef struct packed {
    logic targetDetected;
    logic nearMin;
    logic unlocked;
    logic alternateAdjustMode;
    logic adjustDisabled;
    logic syncMaster;
    logic syncSlave;
    logic syncLost;
  } targetIn_t;

  typedef struct packed {
    logic request;
    logic fault;
  } switchIn_t;

  typedef struct packed {
    logic red;
    logic green;
  } ledOut_t;

endpackage

// [hw/blink_gen.sv]
// Fast, slow and double blink pattern generator
`timescale 1ns/1ns
`default_nettype none
module blink_gen #(
  parameter int unsigned FAST_HALF  = status_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_RATIO = status_pkg::SLOW_RATIO
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      fast,
  output logic      slow,
  output logic      dual
);

  localparam int CW = $clog2(FAST_HALF + 1);
  localparam int SW = $clog2(SLOW_RATIO + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [SW-1:0] slowCnt;
  logic [SW-1:0] next_slowCnt;
  logic [2:0]    phase;
  logic [2:0]    next_phase;
  logic          next_fast;
  logic          next_slow;
  logic          next_dual;
  logic          tick;

  always_comb
  begin
    tick = (cnt == CW'(FAST_HALF - 1));
    next_cnt = tick ? '0 : cnt + CW'(1);
    next_fast = fast ^ tick;
    next_slowCnt = slowCnt;
    next_slow = slow;
    next_phase = phase;
    next_dual = dual;
    if (tick)
    begin
      next_phase = phase + 3'h1;
      next_dual = status_pkg::DUAL_PATTERN[next_phase];
      if (slowCnt == SW'(SLOW_RATIO - 1))
      begin
        next_slowCnt = '0;
        next_slow = ~slow;
      end
      else
        next_slowCnt = slowCnt + SW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      slowCnt <= '0;
      phase <= 3'h0;
      fast <= 1'b0;
      slow <= 1'b0;
      dual <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      slowCnt <= next_slowCnt;
      phase <= next_phase;
      fast <= next_fast;
      slow <= next_slow;
      dual <= next_dual;
    end
  end

endmodule
`default_nettype wire

// [hw/pulse_stretch.sv]
// Stretches an activity pulse to a visible minimum on-time
`timescale 1ns/1ns
`default_nettype none
module pulse_stretch #(
  parameter int unsigned HOLD = status_pkg::ACT_HOLD_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);

  localparam int HW = $clog2(HOLD + 1);

  logic [HW-1:0] cnt;
  logic [HW-1:0] next_cnt;

  // Every new pulse restarts the hold so bursts stay lit
  always_comb
  begin
    if (trigger)
      next_cnt = HW'(HOLD);
    else if (cnt != '0)
      next_cnt = cnt - HW'(1);
    else
      next_cnt = cnt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign active = (cnt != '0);

endmodule
`default_nettype wire

// [dv/sensor_status_asserts.sv]
// Concurrent checks on the status indicator outputs
`timescale 1ns/1ns
`default_nettype none
module sensor_status_asserts (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire status_pkg::targetIn_t  target,
  input wire logic                   adjustButtonPin,
  input wire status_pkg::switchIn_t  switch1,
  input wire logic                   atLowEnd,
  input wire logic                   atHighEnd,
  input wire logic                   rxActivity,
  input wire status_pkg::statusSel_t squareSel,
  input wire status_pkg::ledOut_t    targetLed,
  input wire logic                   squareLed,
  input wire logic [1:0]             switchDrive,
  input wire logic                   filtersEnable,
  input wire logic                   measureEnable,
  input wire logic                   adjustHeld
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Locked, no button, not a slave, for two cycles
  sequence s_plain;
    (!adjustHeld && !target.syncSlave && !target.unlocked)[*2];
  endsequence
  sequence s_lost;
    !(target.syncSlave && target.syncLost) ##1
    (target.syncSlave && target.syncLost && !adjustHeld)[*3];
  endsequence
  sequence s_rx;
    (rxActivity && squareSel == status_pkg::SEL_RX) ##1
    (squareSel == status_pkg::SEL_RX)[*2];
  endsequence

  a_no_dual_colour: assert property (
    !(targetLed.red && targetLed.green))
    else $error("target indicator red and green together");
  a_green_detect: assert property (
    s_plain ##0 (target.targetDetected && !target.nearMin)
    |=> targetLed.green && !targetLed.red)
    else $error("target indicator not steady green");
  a_red_no_target: assert property (
    s_plain ##0 !target.targetDetected |=> targetLed.red && !targetLed.green)
    else $error("target indicator not steady red");
  a_filters_unlock: assert property (
    1'b1 |=> filtersEnable == !$past(target.unlocked))
    else $error("filters enable does not follow unlock");
  a_nosync_stop: assert property (
    s_lost |-> !measureEnable && (targetLed.red != targetLed.green))
    else $error("no sync warning missing");
  a_adjust_sync: assert property (
    $past(rst_n) && $past(rst_n, 2) |-> adjustHeld == $past(adjustButtonPin, 2))
    else $error("button sync delay wrong");
  a_fault_off: assert property (
    switch1.fault |=> !switchDrive[0])
    else $error("faulted switch still driven");
  a_switch_follow: assert property (
    (switch1.request && !switch1.fault && target.targetDetected)[*2]
    |=> switchDrive[0])
    else $error("switch not driven on request");
  a_square_switch: assert property (
    squareSel == status_pkg::SEL_SWITCH && !switch1.fault
    |=> squareLed == $past(switchDrive[0]))
    else $error("square indicator does not follow switch one");
  a_analog_mid: assert property (
    squareSel == status_pkg::SEL_ANALOG && !atLowEnd && !atHighEnd |=> squareLed)
    else $error("analog indicator not on inside span");
  a_rx_flash: assert property (
    s_rx |-> squareLed)
    else $error("receive flash missing");
endmodule

bind sensor_status_indicator_logic sensor_status_asserts
  u_sensor_status_asserts (
  .clk_sys, .rst_n, .target, .adjustButtonPin, .switch1, .atLowEnd,
  .atHighEnd, .rxActivity, .squareSel, .targetLed, .squareLed,
  .switchDrive, .filtersEnable, .measureEnable, .adjustHeld
);
`default_nettype wire

// [dv/test_sensor_status_indicator_logic.sv]
// Directed bench for the status indicator logic
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  errTotal++; $display("CHECK FAILED %s exp %0h seen %0h", n, e, a); \
  end end
module test_sensor_status_indicator_logic;
  logic                     clk_sys;
  logic                     rst_n;
  status_pkg::targetIn_t    target;
  logic                     adjustButtonPin;
  status_pkg::switchIn_t    switch1;
  status_pkg::switchIn_t    switch2;
  logic                     atLowEnd;
  logic                     atHighEnd;
  logic                     rxActivity;
  logic                     txActivity;
  status_pkg::statusSel_t   squareSel;
  status_pkg::statusSel_t   rectSel;
  logic                     noTargetSwitchOff;
  logic                     noTargetAnalogHold;
  status_pkg::ledOut_t      targetLed;
  logic                     squareLed;
  logic                     rectLed;
  logic [1:0]               switchDrive;
  status_pkg::analogLevel_t analogLevel;
  logic                     filtersEnable;
  logic                     measureEnable;
  logic                     adjustHeld;
  int                       errTotal;
  int                       comparisons;
  integer                   nr, ng, ns;

  sensor_status_indicator_logic #(
    .NO_TARGET_TIMEOUT(20), .FAST_HALF(4), .SLOW_RATIO(2), .ACT_HOLD(3)
  ) u_sensor_status_indicator_logic (
    .clk_sys, .rst_n, .target, .adjustButtonPin, .switch1, .switch2,
    .atLowEnd, .atHighEnd, .rxActivity, .txActivity, .squareSel, .rectSel,
    .noTargetSwitchOff, .noTargetAnalogHold, .targetLed, .squareLed,
    .rectLed, .switchDrive, .analogLevel, .filtersEnable, .measureEnable,
    .adjustHeld
  );

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Lit cycles over 32 cycles, one full double blink period and a whole number of fast and slow periods
  task automatic watch();
    nr = 0;
    ng = 0;
    ns = 0;
    repeat (32)
    begin
      @(negedge clk_sys);
      nr += targetLed.red;
      ng += targetLed.green;
      ns += squareLed;
    end
  endtask

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    errTotal++;
    completeRun();
  end

  initial
  begin
    errTotal = 0;
    comparisons = 0;
    rst_n = 1'b0;
    target = '0;
    adjustButtonPin = 1'b0;
    switch1 = '0;
    switch2 = '0;
    atLowEnd = 1'b0;
    atHighEnd = 1'b0;
    rxActivity = 1'b0;
    txActivity = 1'b0;
    squareSel = status_pkg::SEL_OFF;
    rectSel = status_pkg::SEL_OFF;
    noTargetSwitchOff = 1'b1;
    noTargetAnalogHold = 1'b1;
    step(16);
    `CK("reset led", 2'h2, targetLed)
    rst_n = 1'b1;
    target.targetDetected = 1'b1;
    step(3);
    `CK("green", 2'h1, targetLed)
    target.nearMin = 1'b1;
    watch();
    `CK("near green", 16, ng)
    `CK("near red", 0, nr)
    target = '0;
    step(3);
    `CK("red", 2'h2, targetLed)
    target.unlocked = 1'b1;
    watch();
    `CK("unlock red", 16, nr)
    `CK("unlock green", 0, ng)
    `CK("filters", 1'h0, filtersEnable)
    target.alternateAdjustMode = 1'b1;
    watch();
    `CK("dual red", 8, nr)
    $display("test target colours done");
    target = '0;
    adjustButtonPin = 1'b1;
    step(3);
    watch();
    `CK("button red", 16, nr)
    `CK("held", 1'h1, adjustHeld)
    target.adjustDisabled = 1'b1;
    watch();
    `CK("suppressed red", 32, nr)
    target.syncMaster = 1'b1;
    target.alternateAdjustMode = 1'b1;
    watch();
    `CK("master dual red", 8, nr)
    `CK("master dual green", 0, ng)
    adjustButtonPin = 1'b0;
    target = '0;
    target.syncSlave = 1'b1;
    step(3);
    target.syncLost = 1'b1;
    step(3);
    `CK("measure off", 1'h0, measureEnable)
    watch();
    `CK("alt red", 16, nr)
    `CK("alt green", 16, ng)
    adjustButtonPin = 1'b1;
    step(5);
    `CK("override", 1'h1, measureEnable)
    adjustButtonPin = 1'b0;
    target = '0;
    $display("test button and sync done");
    target.targetDetected = 1'b1;
    switch1.request = 1'b1;
    squareSel = status_pkg::SEL_SWITCH;
    rectSel = status_pkg::SEL_SWITCH;
    step(3);
    `CK("drive", 2'h1, switchDrive)
    `CK("square", 1'h1, squareLed)
    `CK("rect", 1'h0, rectLed)
    switch1.fault = 1'b1;
    watch();
    `CK("fault blink", 16, ns)
    `CK("fault off", 2'h0, switchDrive)
    switch1.fault = 1'b0;
    switch2.request = 1'b1;
    step(3);
    `CK("recover", 2'h3, switchDrive)
    `CK("rect on", 1'h1, rectLed)
    target.targetDetected = 1'b0;
    step(10);
    `CK("pre timeout", 2'h3, switchDrive)
    `CK("hold", status_pkg::ANA_HOLD, analogLevel)
    step(15);
    `CK("timed out", 2'h0, switchDrive)
    noTargetSwitchOff = 1'b0;
    noTargetAnalogHold = 1'b0;
    step(3);
    `CK("no timeout", 2'h3, switchDrive)
    `CK("track", status_pkg::ANA_TRACK, analogLevel)
    $display("test switches done");
    target.targetDetected = 1'b1;
    squareSel = status_pkg::SEL_ANALOG;
    step(3);
    `CK("analog mid", 1'h1, squareLed)
    atLowEnd = 1'b1;
    step(3);
    `CK("analog low", 1'h0, squareLed)
    `CK("level low", status_pkg::ANA_LOW, analogLevel)
    atHighEnd = 1'b1;
    watch();
    `CK("analog high", 16, ns)
    `CK("level high", status_pkg::ANA_HIGH, analogLevel)
    atHighEnd = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rectSel = status_pkg::statusSel_t'(i);
      step(3);
      `CK("rect sel", i == 2, rectLed)
    end
    $display("test analog and select done");
    squareSel = status_pkg::SEL_RX;
    rectSel = status_pkg::SEL_TX;
    rxActivity = 1'b1;
    step(1);
    rxActivity = 1'b0;
    txActivity = 1'b1;
    step(1);
    txActivity = 1'b0;
    `CK("rx on", 1'h1, squareLed)
    step(1);
    `CK("tx on", 1'h1, rectLed)
    step(8);
    `CK("rx off", 1'h0, squareLed)
    `CK("tx off", 1'h0, rectLed)
    $display("test serial activity done");
    completeRun();
  end
endmodule
`default_nettype wire
